/* include/core_pipe_params.svh */
// Offsets, field positions, reset values and masks of the core pipeline.
`ifndef CORE_PIPE_PARAMS_SVH
`define CORE_PIPE_PARAMS_SVH

`define PHASE_COUNT 4
`define PHASE_ONE_BIT 0
`define PHASE_TWO_BIT 1
`define PHASE_THREE_BIT 2
`define PHASE_FOUR_BIT 3
`define PHASE_RESET 4'h8

`define PC_MASK_SMALL 10'h1ff
`define PC_MASK_LARGE 10'h3ff
`define PMEM_MASK_SMALL 9'h0ff
`define PMEM_MASK_LARGE 9'h1ff
`define PC_RESET 10'h3ff
`define RESET_VECTOR 10'h000
`define INSTR_NOP 12'h000

`define ADDR_INDIRECT 5'h00
`define ADDR_TIMER 5'h01
`define ADDR_PC_LOW 5'h02
`define ADDR_FLAGS 5'h03
`define ADDR_POINTER 5'h04
`define ADDR_OSC_TRIM 5'h05
`define ADDR_PORT 5'h06
`define ADDR_COMPARATOR 5'h07
`define GPR_BASE_SMALL 5'h10
`define GPR_BASE_LARGE 5'h08
`define GPR_DEPTH 24

`define FLAG_C 0
`define FLAG_DC 1
`define FLAG_Z 2
`define FLAG_PD 3
`define FLAG_TO 4
`define FLAG_CWUF 6
`define FLAG_GPWUF 7
`define FLAGS_RESET 8'h18
`define POINTER_UPPER 3'h7
`define OSC_TRIM_RESET 8'hfe
`define COMPARATOR_RESET 8'hff
`define OPTION_RESET 8'hff
`define DIRECTION_RESET 4'hf

`endif

/* include/core_pipe_pkg.sv */
// Types shared by the core pipeline design files.
package core_pipe_pkg;
	typedef logic [11:0] word_t;
	typedef logic [7:0] byte_t;
	typedef logic [4:0] file_addr_t;
	typedef logic [9:0] pc_t;
	typedef logic [8:0] pmem_addr_t;
	typedef logic [3:0] nibble_t;
	typedef logic [2:0] alu_flags_t;
endpackage

/* verilog/phase_gen.sv */
// Four-phase ring that splits each instruction cycle into phases one to four.
`timescale 1ns/100ps
`include "core_pipe_params.svh"
module phase_gen (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Holds the ring at phase four so the next cycle is phase one
	input wire logic restart,
	// One-hot phases, bit 0 is phase one
	output logic [3:0] phase
);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase <= `PHASE_RESET;
		end else if (restart) begin
			phase <= `PHASE_RESET;
		end else begin
			phase <= {phase[2:0], phase[3]};
		end
	end
endmodule

/* verilog/gpr_file.sv */
// General-purpose register storage, one flip-flop byte per entry.
`timescale 1ns/100ps
`include "core_pipe_params.svh"
module gpr_file (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Write port
	input wire logic we,
	input wire core_pipe_pkg::file_addr_t waddr,
	input wire core_pipe_pkg::byte_t wdata,
	// Read port
	input wire core_pipe_pkg::file_addr_t raddr,
	output core_pipe_pkg::byte_t rdata
);
	import core_pipe_pkg::*;

	byte_t mem [`GPR_DEPTH];
	wire raddr_ok = raddr < 5'(`GPR_DEPTH);

	for (genvar i = 0; i < `GPR_DEPTH; i++) begin : g_entry
		wire hit = we && (waddr == 5'(i));
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				mem[i] <= 8'h00;
			end else if (hit) begin
				mem[i] <= wdata;
			end
		end
	end

	assign rdata = raddr_ok ? mem[raddr] : 8'h00;
endmodule

/* verilog/core_pipeline_memmap.sv */
// Core timing, two-stage pipeline and register-file map.
//
// Function
// [RULE1] Divide clock by four into phases.
// [RULE2] PC advances phase one, fetch ends phase four.
// [RULE3] Fetch and execute overlap, one per cycle.
// [RULE4] Branches take two cycles, prefetch discarded.
// [RULE5] Instruction register loads in phase one.
// [RULE6] Operand read phase two, write phase four.
// [RULE7] Small variant: 9-bit PC, 256 words.
// [RULE8] Large variant: 10-bit PC, 512 words.
// [RULE9] Out-of-range program addresses wrap around.
// [RULE10] Execution starts at 0000h after reset.
// [RULE11] Last program word holds oscillator trim.
// [RULE12] Register file sizes per variant.
// [RULE13] GPRs reachable directly and indirectly.
// [RULE14] Address 00h redirects through indirect pointer.
// [RULE15] Only PC low byte visible at 02h.
// [RULE16] Unimplemented locations and bits read zero; the pointer's upper three bits read one.
// [RULE17] Pin, watchdog and wake resets supported.
// [RULE18] Computed flags override direct flag writes.
// [RULE19] Flushed slot executes as no-operation.
`timescale 1ns/100ps
`include "core_pipe_params.svh"
module core_pipeline_memmap #(
	parameter bit large_variant = 1'b0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Reset sources
	input wire logic reset_pin_n,
	input wire logic wdt_timeout,
	input wire logic pin_wake,
	// Phase clocks
	output logic [3:0] phase,
	// Program memory
	output core_pipe_pkg::pmem_addr_t pmem_addr,
	input wire core_pipe_pkg::word_t pmem_data,
	// Decoder and ALU side
	output core_pipe_pkg::word_t instr,
	output core_pipe_pkg::byte_t operand_data,
	output core_pipe_pkg::byte_t core_flags,
	input wire core_pipe_pkg::file_addr_t exec_file_addr,
	input wire logic exec_file_write,
	input wire core_pipe_pkg::byte_t exec_write_data,
	input wire core_pipe_pkg::alu_flags_t exec_flags_update,
	input wire core_pipe_pkg::alu_flags_t exec_flags,
	input wire logic exec_branch,
	input wire core_pipe_pkg::pc_t exec_branch_target,
	input wire logic exec_tris_write,
	input wire logic exec_option_write,
	// Peripheral side
	input wire logic timer_tick,
	input wire core_pipe_pkg::nibble_t port_pins_in,
	output core_pipe_pkg::byte_t timer_count,
	output core_pipe_pkg::byte_t osc_trim,
	output core_pipe_pkg::nibble_t port_latch,
	output core_pipe_pkg::nibble_t port_direction,
	output core_pipe_pkg::byte_t timer_prescale_config,
	output core_pipe_pkg::byte_t comparator_ctrl
);
	import core_pipe_pkg::*;

	// The reset pin is asynchronous to clk and is filtered through three stages.
	logic pin_s1, pin_s2, pin_s3, pin_level;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_s1 <= 1'b1;
			pin_s2 <= 1'b1;
			pin_s3 <= 1'b1;
		end else begin
			pin_s1 <= reset_pin_n;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_level <= 1'b1;
		end else if (pin_s2 == pin_s3) begin
			pin_level <= pin_s3;
		end
	end

	// Port pins are asynchronous as well and pass the same three-stage filter, bit by bit.
	nibble_t port_s1, port_s2, port_s3, port_level;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			port_s1 <= 4'h0;
			port_s2 <= 4'h0;
			port_s3 <= 4'h0;
		end else begin
			port_s1 <= port_pins_in;
			port_s2 <= port_s1;
			port_s3 <= port_s2;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			port_level <= 4'h0;
		end else begin
			// A bit follows its pin only while stages two and three agree.
			port_level <= (port_s2 & port_s3) | (port_level & (port_s2 ^ port_s3));
		end
	end

	// [RULE17] Any reset source
	wire soft_active = !pin_level || wdt_timeout || pin_wake;

	// [RULE1] Phase ring
	phase_gen u_phase (
		.clk(clk),
		.rst(rst),
		.restart(soft_active),
		.phase(phase)
	);
	wire ph_one = phase[`PHASE_ONE_BIT] && !soft_active;
	wire ph_two = phase[`PHASE_TWO_BIT] && !soft_active;
	wire ph_four = phase[`PHASE_FOUR_BIT] && !soft_active;

	// [RULE7] [RULE8] Variant address widths
	wire pc_t pc_mask = large_variant ? `PC_MASK_LARGE : `PC_MASK_SMALL;
	wire pmem_addr_t pmem_mask = large_variant ? `PMEM_MASK_LARGE : `PMEM_MASK_SMALL;
	wire file_addr_t gpr_base = large_variant ? `GPR_BASE_LARGE : `GPR_BASE_SMALL;

	// The counter resets to all ones within its own width, so it never leaves the variant's space.
	localparam pc_t pc_start = `PC_RESET & (large_variant ? `PC_MASK_LARGE : `PC_MASK_SMALL);

	pc_t pc;
	word_t fetch_word;
	logic jump_pending;
	pc_t jump_target;

	// [RULE4] A pending jump replaces the increment
	wire pc_t pc_inc = (pc + 10'h001) & pc_mask;
	wire pc_t next_pc = jump_pending ? jump_target : pc_inc;

	// [RULE2] PC advances in phase one
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pc <= pc_start;
			pmem_addr <= 9'h000;
		end else if (soft_active) begin
			pc <= pc_start;
		end else if (ph_one) begin
			pc <= next_pc;
			// [RULE9] [RULE11] Implemented bits reach the last word
			pmem_addr <= next_pc[8:0] & pmem_mask;
		end
	end

	// [RULE2] [RULE3] Fetch overlaps execution
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fetch_word <= `INSTR_NOP;
		end else if (ph_four) begin
			fetch_word <= pmem_data;
		end
	end

	// [RULE5] [RULE19] Load or flush the instruction register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			instr <= `INSTR_NOP;
		end else if (soft_active) begin
			instr <= `INSTR_NOP;
		end else if (ph_one) begin
			instr <= jump_pending ? `INSTR_NOP : fetch_word;
		end
	end

	// [RULE14] Indirect redirection through the pointer
	logic [4:0] pointer;
	wire file_addr_t eff_addr = (exec_file_addr == `ADDR_INDIRECT) ? pointer : exec_file_addr;
	wire is_gpr = eff_addr >= gpr_base;
	wire is_cmp = large_variant && (eff_addr == `ADDR_COMPARATOR);
	wire file_addr_t gpr_index = eff_addr - gpr_base;
	byte_t gpr_rdata;

	// [RULE12] [RULE13] General-purpose storage
	wire file_we = ph_four && exec_file_write;
	gpr_file u_gpr (
		.clk(clk),
		.rst(rst),
		.we(file_we && is_gpr),
		.waddr(gpr_index),
		.wdata(exec_write_data),
		.raddr(gpr_index),
		.rdata(gpr_rdata)
	);

	// [RULE15] [RULE16] Read selection, unimplemented reads zero
	wire byte_t sfr_rdata =
		(eff_addr == `ADDR_TIMER) ? timer_count :
		(eff_addr == `ADDR_PC_LOW) ? pc[7:0] :
		(eff_addr == `ADDR_FLAGS) ? core_flags :
		(eff_addr == `ADDR_POINTER) ? {`POINTER_UPPER, pointer} :
		(eff_addr == `ADDR_OSC_TRIM) ? osc_trim :
		(eff_addr == `ADDR_PORT) ? {4'h0, port_level} :
		is_cmp ? comparator_ctrl : 8'h00;
	wire byte_t file_rdata = is_gpr ? gpr_rdata : sfr_rdata;

	// [RULE6] Operand read in phase two
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			operand_data <= 8'h00;
		end else if (ph_two) begin
			operand_data <= file_rdata;
		end
	end

	wire wr_pc = file_we && (eff_addr == `ADDR_PC_LOW);
	wire wr_flags = file_we && (eff_addr == `ADDR_FLAGS);

	// [RULE4] [RULE10] [RULE15] Jump capture; a PC low write clears the upper bits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			jump_pending <= 1'b1;
			jump_target <= `RESET_VECTOR;
		end else if (soft_active) begin
			jump_pending <= 1'b1;
			jump_target <= `RESET_VECTOR;
		end else if (ph_four && (exec_branch || wr_pc)) begin
			jump_pending <= 1'b1;
			jump_target <= exec_branch ? (exec_branch_target & pc_mask) : {2'b00, exec_write_data};
		end else if (ph_one) begin
			jump_pending <= 1'b0;
		end
	end

	// [RULE18] Computed flags win over a direct write
	wire alu_flags_t flag_now = core_flags[2:0];
	wire alu_flags_t flag_wr = wr_flags ? exec_write_data[2:0] : flag_now;
	wire alu_flags_t next_alu_flags = (exec_flags_update & exec_flags) | (~exec_flags_update & flag_wr);

	// [RULE17] Reset cause flags
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			core_flags <= `FLAGS_RESET;
		end else if (soft_active) begin
			core_flags[`FLAG_GPWUF] <= pin_wake;
			core_flags[`FLAG_CWUF] <= 1'b0;
			core_flags[`FLAG_TO] <= !wdt_timeout;
		end else if (ph_four) begin
			core_flags[2:0] <= next_alu_flags;
			if (wr_flags) begin
				core_flags[7:6] <= exec_write_data[7:6];
			end
		end
	end

	// Remaining special-function registers, written in phase four.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			timer_count <= 8'h00;
			pointer <= 5'h00;
			osc_trim <= `OSC_TRIM_RESET;
			port_latch <= 4'h0;
			comparator_ctrl <= `COMPARATOR_RESET;
		end else begin
			if (file_we && eff_addr == `ADDR_TIMER) begin
				timer_count <= exec_write_data;
			end else if (timer_tick) begin
				timer_count <= timer_count + 8'h01;
			end
			if (file_we && eff_addr == `ADDR_POINTER) begin
				pointer <= exec_write_data[4:0];
			end
			if (file_we && eff_addr == `ADDR_OSC_TRIM) begin
				osc_trim <= exec_write_data;
			end
			if (file_we && eff_addr == `ADDR_PORT) begin
				port_latch <= exec_write_data[3:0];
			end
			if (file_we && is_cmp) begin
				comparator_ctrl <= exec_write_data;
			end
		end
	end

	// Direction and prescaler settings are loaded by their own instructions.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			port_direction <= `DIRECTION_RESET;
			timer_prescale_config <= `OPTION_RESET;
		end else if (soft_active) begin
			port_direction <= `DIRECTION_RESET;
			timer_prescale_config <= `OPTION_RESET;
		end else if (ph_four) begin
			if (exec_tris_write) begin
				port_direction <= exec_write_data[3:0];
			end
			if (exec_option_write) begin
				timer_prescale_config <= exec_write_data;
			end
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	phase_ring_a: assert property ( // [RULE1]
		$onehot(phase) && (phase[`PHASE_ONE_BIT] && !soft_active) |=> phase[`PHASE_TWO_BIT] ##1
		phase[`PHASE_THREE_BIT] ##1 phase[`PHASE_FOUR_BIT])
		else $error("phase ring did not step one to four");

	pc_advance_a: assert property ( // [RULE2]
		ph_one && !jump_pending |=> pc == (($past(pc) + 10'h001) & pc_mask))
		else $error("pc did not advance in phase one");

	fetch_latch_a: assert property ( // [RULE2]
		ph_four |=> fetch_word == $past(pmem_data))
		else $error("fetch word not captured in phase four");

	ir_load_a: assert property ( // [RULE5]
		ph_one && !jump_pending |=> instr == $past(fetch_word) && !jump_pending)
		else $error("instruction register not loaded in phase one");

	branch_flush_a: assert property ( // [RULE4]
		ph_four && exec_branch |=> (ph_one && jump_pending) ##1
		(instr == `INSTR_NOP && pc == $past(jump_target)))
		else $error("branch did not flush and redirect");

	operand_hold_a: assert property ( // [RULE6]
		!ph_two |=> operand_data == $past(operand_data))
		else $error("operand changed outside phase two");

	write_phase_a: assert property ( // [RULE6]
		(timer_count != $past(timer_count)) && !$past(timer_tick) |-> $past(phase[`PHASE_FOUR_BIT]))
		else $error("register write outside phase four");

	wrap_range_a: assert property ( // [RULE9]
		(pmem_addr & ~pmem_mask) == 9'h000 && (pc & ~pc_mask) == 10'h000)
		else $error("program address outside implemented space");

	reset_vector_a: assert property ( // [RULE10]
		$fell(soft_active) |-> ##2 (pmem_addr == 9'h000 && instr == `INSTR_NOP))
		else $error("reset did not restart at vector zero");

	unimpl_zero_a: assert property ( // [RULE16]
		ph_two && !is_gpr && eff_addr > 5'h07 |=> operand_data == 8'h00)
		else $error("unimplemented location read nonzero");

	flag_guard_a: assert property ( // [RULE18]
		ph_four && wr_flags && exec_flags_update[`FLAG_Z] |=> core_flags[`FLAG_Z] == $past(exec_flags[`FLAG_Z]))
		else $error("direct write overrode computed zero flag");

	branch_taken_c: cover property (ph_four && exec_branch);
	flags_write_c: cover property (ph_four && wr_flags && exec_flags_update != 3'h0);
	indirect_read_c: cover property (ph_two && exec_file_addr == `ADDR_INDIRECT && is_gpr);
	pc_write_c: cover property (wr_pc);
endmodule

/* verif/prog_mem_model.sv */
// Program memory model: 256 words, the last one holding the oscillator trim word.
`timescale 1ns/100ps
module prog_mem_model #(
	parameter int latency = 1,
	parameter logic [11:0] trim_word = 12'h5c3
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Fetch port
	input wire core_pipe_pkg::pmem_addr_t pmem_addr,
	output core_pipe_pkg::word_t pmem_data
);
	import core_pipe_pkg::*;
	pmem_addr_t held;
	logic [2:0] age;
	word_t word;
	// only the low byte selects a word; the last word is the trim.
	assign word = (held[7:0] == 8'hff) ? trim_word : {4'ha, held[7:0]};
	// Until the access time has run out the data lines show the inverse of the word.
	assign pmem_data = (held == pmem_addr && int'(age) >= latency) ? word : ~word;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			held <= '0;
			age <= '0;
		end else if (held != pmem_addr) begin
			held <= pmem_addr;
			age <= '0;
		end else if (age != 3'h7) begin
			age <= age + 3'h1;
		end
	end
endmodule

/* verif/testbench.sv */
// Self-checking bench for the core pipeline and register-file map.
`timescale 1ns/100ps
module testbench;
	import core_pipe_pkg::*;
	localparam logic [11:0] trim = 12'h5c3;
	localparam logic [4:0] addrs [8] = '{5'h07, 5'h08, 5'h0f, 5'h1f, 5'h10, 5'h06, 5'h01, 5'h05};
	localparam byte_t rexp [8] = '{8'h00, 8'h00, 8'h00, 8'h3c, 8'h3c, 8'h0a, 8'h3c, 8'h3c};
	localparam byte_t fexp [3] = '{8'h1a, 8'h0a, 8'h9a};
	logic clk, rst, reset_pin_n, wdt_timeout, pin_wake, timer_tick;
	logic exec_file_write, exec_branch, exec_tris_write, exec_option_write;
	logic [3:0] phase;
	pmem_addr_t pmem_addr;
	word_t pmem_data, instr, eins;
	byte_t operand_data, core_flags, timer_count, osc_trim, timer_prescale_config, comparator_ctrl, rd;
	byte_t exec_write_data;
	file_addr_t exec_file_addr;
	alu_flags_t exec_flags_update, exec_flags;
	pc_t exec_branch_target, epc, pc_now;
	nibble_t port_pins_in, port_latch, port_direction;
	int failures, n_compared;

	core_pipeline_memmap #(.large_variant(1'b0)) i_core_pipeline_memmap (.clk, .rst, .reset_pin_n, .wdt_timeout,
		.pin_wake, .phase, .pmem_addr, .pmem_data, .instr, .operand_data, .core_flags, .exec_file_addr,
		.exec_file_write, .exec_write_data, .exec_flags_update, .exec_flags, .exec_branch, .exec_branch_target,
		.exec_tris_write, .exec_option_write, .timer_tick, .port_pins_in, .timer_count, .osc_trim, .port_latch,
		.port_direction, .timer_prescale_config, .comparator_ctrl);
	prog_mem_model #(.trim_word(trim)) i_prog_mem_model (.clk, .rst, .pmem_addr, .pmem_data);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic word_t ew(input pc_t a);
		return (a[7:0] == 8'hff) ? trim : {4'ha, a[7:0]};
	endfunction

	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Waits out the idle first cycle after any reset and stops at a phase-one start.
	task automatic align();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (phase !== 4'h1 && n < 40);
		if (n >= 40) begin
			failures++;
			stop_test();
		end
		repeat (3) @(posedge clk);
		epc = 10'h001;
		eins = ew(10'h000);
	endtask

	// One instruction cycle as the decoder would drive it, checking fetch and phases.
	task automatic cyc(input file_addr_t a, input logic w, input byte_t d, input alu_flags_t u,
			input alu_flags_t f, input logic br, input pc_t t);
		exec_file_addr <= a;
		exec_file_write <= w;
		exec_write_data <= d;
		exec_flags_update <= u;
		exec_flags <= f;
		exec_branch <= br;
		exec_branch_target <= t;
		pc_now = epc;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			check("phase", {8'h0, phase}, {8'h0, 4'h1 << i});
			if (i == 2) begin
				rd = operand_data;
				check("pmem_addr", {3'h0, pmem_addr}, {4'h0, epc[7:0]});
				check("instr", instr, eins);
			end
		end
		if (br || (w && a == 5'h02)) begin
			eins = 12'h000;
			epc = br ? t : {2'b00, d};
		end else begin
			eins = ew(epc);
			epc = (epc + 10'h001) & 10'h1ff;
		end
	endtask

	initial begin
		{rst, reset_pin_n, wdt_timeout, pin_wake, timer_tick} = 5'b11000;
		{exec_file_write, exec_branch, exec_tris_write, exec_option_write} = 4'h0;
		{exec_file_addr, exec_write_data, exec_flags_update, exec_flags} = '0;
		exec_branch_target = 10'h000;
		port_pins_in = 4'ha;
		failures = 0;
		n_compared = 0;
		repeat (2) @(posedge clk);
		check("reset phase", {8'h0, phase}, 12'h008);
		check("flags", {4'h0, core_flags}, 12'h018);
		check("trim", {4'h0, osc_trim}, 12'h0fe);
		check("cmp", {4'h0, comparator_ctrl}, 12'h0ff);
		check("option", {4'h0, timer_prescale_config}, 12'h0ff);
		check("dir", {8'h0, port_direction}, 12'h00f);
		rst <= 1'b0;
		align();
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			cyc(addrs[i], 1'b1, 8'h3c, 3'h0, 3'h0, 1'b0, 10'h000);
			cyc(addrs[i], 1'b0, 8'h00, 3'h0, 3'h0, 1'b0, 10'h000);
			check("file", {4'h0, rd}, {4'h0, rexp[i]});
		end
		check("latch", {8'h0, port_latch}, 12'h00c);
		check("trim", {4'h0, osc_trim}, 12'h03c);
		check("cmp", {4'h0, comparator_ctrl}, 12'h0ff);
		$display("test file map done");
		cyc(5'h04, 1'b1, 8'h10, 3'h0, 3'h0, 1'b0, 10'h000);
		cyc(5'h00, 1'b1, 8'ha5, 3'h0, 3'h0, 1'b0, 10'h000);
		check("indirect", {4'h0, rd}, 12'h03c);
		cyc(5'h10, 1'b0, 8'h00, 3'h0, 3'h0, 1'b0, 10'h000);
		check("gpr", {4'h0, rd}, 12'h0a5);
		cyc(5'h04, 1'b0, 8'h00, 3'h0, 3'h0, 1'b0, 10'h000);
		check("pointer", {4'h0, rd}, 12'h0f0);
		$display("test indirect done");
		cyc(5'h03, 1'b1, 8'h07, 3'b101, 3'b010, 1'b0, 10'h000);
		cyc(5'h03, 1'b0, 8'h00, 3'h0, 3'h0, 1'b0, 10'h000);
		check("flags", {4'h0, rd}, 12'h01a);
		$display("test flags done");
		cyc(5'h02, 1'b0, 8'h00, 3'h0, 3'h0, 1'b0, 10'h000);
		check("pc low", {4'h0, rd}, {4'h0, pc_now[7:0]});
		cyc(5'h02, 1'b1, 8'h40, 3'h0, 3'h0, 1'b0, 10'h000);
		cyc(5'h02, 1'b0, 8'h00, 3'h0, 3'h0, 1'b1, 10'h1fe);
		repeat (4) cyc(5'h10, 1'b0, 8'h00, 3'h0, 3'h0, 1'b0, 10'h000);
		$display("test branch done");
		exec_tris_write <= 1'b1;
		exec_option_write <= 1'b1;
		timer_tick <= 1'b1;
		cyc(5'h10, 1'b0, 8'h35, 3'h0, 3'h0, 1'b0, 10'h000);
		exec_tris_write <= 1'b0;
		exec_option_write <= 1'b0;
		timer_tick <= 1'b0;
		cyc(5'h10, 1'b0, 8'h00, 3'h0, 3'h0, 1'b0, 10'h000);
		check("dir", {8'h0, port_direction}, 12'h005);
		check("option", {4'h0, timer_prescale_config}, 12'h035);
		check("timer", {4'h0, timer_count}, 12'h040);
		$display("test config done");
		for (int s = 0; s < 3; s++) begin
			reset_pin_n <= (s != 0);
			wdt_timeout <= (s == 1);
			pin_wake <= (s == 2);
			repeat (8) @(posedge clk);
			check("held phase", {8'h0, phase}, 12'h008);
			check("dir", {8'h0, port_direction}, 12'h00f);
			reset_pin_n <= 1'b1;
			wdt_timeout <= 1'b0;
			pin_wake <= 1'b0;
			align();
			check("flags", {4'h0, core_flags}, {4'h0, fexp[s]});
			repeat (2) cyc(5'h10, 1'b0, 8'h00, 3'h0, 3'h0, 1'b0, 10'h000);
		end
		$display("test soft resets done");
		stop_test();
	end
endmodule
